// ### core/reply_timeout_tag_release.sv
// Reply-timeout monitors for both channels and transmit-tag release logic
`timescale 1ns/1ps
// How it works
// - Bit 7 sets when the device reply misses its allowed delay.
// - Each flag set raises that channel's receive-error interrupt.
// - Reading the reply-timeout register clears the flag; other fields unchanged.
// - Bits 6:5 add 0..3 bit intervals to the inter-byte limit.
// - Bits 4:1 add 0..15 bit intervals to the ten-bit reply limit.
// - Bit 0 on starts reply timing at the master's last stop bit.
// - Late first reply or late inter-byte gap both flag and interrupt.
// - Bit 0 off stops monitoring and the flag reads zero.
// - Channel B has an identical independent register at 0x15.
// - Tag register bits 7:4 hold channel A's 4-bit transmit tag.
// - Matching trigger write releases queued message and starts enabled cycle timer.
// - Trigger value zero always releases both channels.
// - Tag register bit 0 off ignores the assigned tag.
// - Unused tag register bits 3:1 read as zero.
// - Cycle timer starts only when its control enable bit is set.

////////////////////////////////////////////////////////////////////////////////

module reply_monitor
	import reply_timing_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Configuration
	input wire logic [6:0] cfg,
	input wire logic [12:0] bit_len,
	// Framer events and flag clear
	input wire link_evt_s evt,
	input wire logic rd_clr,
	// Status
	output logic late_flag,
	output logic fault_irq
);
	mon_state_e state;
	logic [12:0] cyc;
	logic [4:0] bits;
	logic [4:0] limit;
	logic mon_on;
	logic wrap;
	logic timeout;

	assign mon_on = cfg[MONITOR_ON_BIT];
	assign wrap = (cyc == bit_len - 13'h0001);
	assign limit = (state == MON_GAP) ?
		INTERBYTE_BASE_BITS + {3'h0, cfg[INTERBYTE_SLACK_HI:INTERBYTE_SLACK_LO]} :
		REPLY_BASE_BITS + {1'h0, cfg[REPLY_SLACK_HI:REPLY_SLACK_LO]};
	assign timeout = ((state == MON_WAIT_REPLY) || (state == MON_GAP)) && wrap && (bits == limit - 5'h01);

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= MON_IDLE;
		end else if (ce) begin
			if (!mon_on) begin
				state <= MON_IDLE;
			end else if (evt.tx_done) begin
				state <= MON_WAIT_REPLY;
			end else begin
				case (state)
					MON_WAIT_REPLY, MON_GAP: begin
						if (timeout || evt.rx_msg_done) begin // End of reply also closes the gap timer
							state <= MON_IDLE;
						end else if (evt.rx_start) begin
							state <= MON_RECV;
						end
					end
					MON_RECV: begin
						if (evt.rx_msg_done) begin
							state <= MON_IDLE;
						end else if (evt.rx_byte_done) begin
							state <= MON_GAP;
						end
					end
					default: state <= MON_IDLE;
				endcase
			end
		end
	end

	// Bit-interval timer, restarted at each phase boundary
	always_ff @(posedge clk) begin
		if (srst) begin
			cyc <= 13'h0000;
			bits <= 5'h00;
		end else if (ce) begin
			if (evt.tx_done || evt.rx_byte_done || state == MON_IDLE || state == MON_RECV) begin
				cyc <= 13'h0000;
				bits <= 5'h00;
			end else if (wrap) begin
				cyc <= 13'h0000;
				bits <= bits + 5'h01;
			end else begin
				cyc <= cyc + 13'h0001;
			end
		end
	end

	// Set wins over the read clear so a late reply is never lost
	always_ff @(posedge clk) begin
		if (srst) begin
			late_flag <= 1'b0;
			fault_irq <= 1'b0;
		end else if (ce) begin
			fault_irq <= mon_on && timeout;
			if (!mon_on) begin
				late_flag <= 1'b0;
			end else if (timeout) begin
				late_flag <= 1'b1;
			end else if (rd_clr) begin
				late_flag <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	late_set_a: assert property (ce && mon_on && timeout |=> late_flag && fault_irq)
		else $error("late reply did not set flag and interrupt");
	irq_cause_a: assert property (ce && fault_irq |-> late_flag && $past(timeout))
		else $error("interrupt without a late reply");
	read_clear_a: assert property (ce && rd_clr && !timeout && $past(ce) |=> !late_flag)
		else $error("read did not clear flag");
	off_zero_a: assert property (ce && !mon_on |=> !late_flag && state == MON_IDLE)
		else $error("flag set while monitor off");
	start_timing_a: assert property (ce && mon_on && evt.tx_done |=> state == MON_WAIT_REPLY && bits == 5'h00)
		else $error("reply timing did not start");
	msg_end_a: assert property (ce && mon_on && !evt.tx_done && state == MON_GAP && evt.rx_msg_done
		|=> state == MON_IDLE)
		else $error("reply end did not stop gap timing");
	bound_bits_a: assert property (state == MON_WAIT_REPLY || state == MON_GAP |-> bits < limit)
		else $error("bit count passed its limit");
	cover_late: cover property (ce && mon_on && timeout);
	cover_gap_late: cover property (ce && state == MON_GAP && timeout);
endmodule // reply_monitor

////////////////////////////////////////////////////////////////////////////////

module reply_timeout_tag_release
	import reply_timing_pkg::*;
#(
	parameter int BIT_CYC_SLOW = BIT_CYC_COM1
)(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Register port from the serial host interface
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Trigger register write
	input wire logic trig_wr,
	input wire logic [3:0] trig_val,
	// Per-channel framer state and cycle-timer enables
	input wire link_evt_s line_a_evt,
	input wire link_evt_s line_b_evt,
	input wire logic [1:0] line_a_rate,
	input wire logic [1:0] line_b_rate,
	input wire logic chan_a_period_timer_on,
	input wire logic chan_b_period_timer_on,
	// Results
	output logic chan_a_receive_fault_irq,
	output logic chan_b_receive_fault_irq,
	output logic chan_a_tx_release,
	output logic chan_b_tx_release,
	output logic chan_a_period_timer_start,
	output logic chan_b_period_timer_start
);
	logic [6:0] chan_a_timeout_reg;
	logic [6:0] chan_b_timeout_reg;
	logic [3:0] chan_a_tx_tag;
	logic [3:0] chan_b_tx_tag;
	logic chan_a_tag_release_on;
	logic chan_b_tag_release_on;
	logic chan_a_late_reply_flag;
	logic chan_b_late_reply_flag;
	logic match_a;
	logic match_b;

	function automatic logic [12:0] bit_cycles(input logic [1:0] rate);
		case (rate)
			RATE_COM1: bit_cycles = BIT_CYC_SLOW[12:0];
			RATE_COM2: bit_cycles = BIT_CYC_COM2[12:0];
			default: bit_cycles = BIT_CYC_COM3[12:0];
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (srst) begin
			chan_a_timeout_reg <= TIMEOUT_CFG_RESET;
			chan_b_timeout_reg <= TIMEOUT_CFG_RESET;
			{chan_a_tx_tag, chan_a_tag_release_on} <= TAG_ASSIGN_RESET;
			{chan_b_tx_tag, chan_b_tag_release_on} <= TAG_ASSIGN_RESET;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				CHAN_A_REPLY_TIMEOUT_CFG_ADDR: chan_a_timeout_reg <= reg_wdata[6:0];
				CHAN_B_REPLY_TIMEOUT_CFG_ADDR: chan_b_timeout_reg <= reg_wdata[6:0];
				CHAN_A_TX_TAG_ASSIGN_ADDR: begin
					chan_a_tx_tag <= reg_wdata[TAG_HI:TAG_LO];
					chan_a_tag_release_on <= reg_wdata[TAG_RELEASE_ON_BIT];
				end
				CHAN_B_TX_TAG_ASSIGN_ADDR: begin
					chan_b_tx_tag <= reg_wdata[TAG_HI:TAG_LO];
					chan_b_tag_release_on <= reg_wdata[TAG_RELEASE_ON_BIT];
				end
				default: ;
			endcase
		end
	end

	// Read data is captured before the clear lands
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				CHAN_A_REPLY_TIMEOUT_CFG_ADDR: reg_rdata <= {chan_a_late_reply_flag, chan_a_timeout_reg};
				CHAN_B_REPLY_TIMEOUT_CFG_ADDR: reg_rdata <= {chan_b_late_reply_flag, chan_b_timeout_reg};
				CHAN_A_TX_TAG_ASSIGN_ADDR: reg_rdata <= {chan_a_tx_tag, 3'h0, chan_a_tag_release_on};
				CHAN_B_TX_TAG_ASSIGN_ADDR: reg_rdata <= {chan_b_tx_tag, 3'h0, chan_b_tag_release_on};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	reply_monitor mon_a (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.cfg(chan_a_timeout_reg),
		.bit_len(bit_cycles(line_a_rate)),
		.evt(line_a_evt),
		.rd_clr(reg_rd && reg_addr == CHAN_A_REPLY_TIMEOUT_CFG_ADDR),
		.late_flag(chan_a_late_reply_flag),
		.fault_irq(chan_a_receive_fault_irq)
	);

	reply_monitor mon_b (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.cfg(chan_b_timeout_reg),
		.bit_len(bit_cycles(line_b_rate)),
		.evt(line_b_evt),
		.rd_clr(reg_rd && reg_addr == CHAN_B_REPLY_TIMEOUT_CFG_ADDR),
		.late_flag(chan_b_late_reply_flag),
		.fault_irq(chan_b_receive_fault_irq)
	);

	// Zero is hard-wired to both channels whatever the enables say
	assign match_a = trig_wr && ((trig_val == GLOBAL_TAG) ||
		(chan_a_tag_release_on && trig_val == chan_a_tx_tag));
	assign match_b = trig_wr && ((trig_val == GLOBAL_TAG) ||
		(chan_b_tag_release_on && trig_val == chan_b_tx_tag));

	always_ff @(posedge clk) begin
		if (srst) begin
			chan_a_tx_release <= 1'b0;
			chan_b_tx_release <= 1'b0;
			chan_a_period_timer_start <= 1'b0;
			chan_b_period_timer_start <= 1'b0;
		end else if (ce) begin
			chan_a_tx_release <= match_a;
			chan_b_tx_release <= match_b;
			chan_a_period_timer_start <= match_a && chan_a_period_timer_on;
			chan_b_period_timer_start <= match_b && chan_b_period_timer_on;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	global_tag_a: assert property (ce && trig_wr && trig_val == GLOBAL_TAG |=> chan_a_tx_release && chan_b_tx_release)
		else $error("global tag did not release both channels");
	tag_match_a: assert property (ce && trig_wr && chan_a_tag_release_on && trig_val == chan_a_tx_tag
		|=> chan_a_tx_release)
		else $error("matching tag did not release channel a");
	tag_off_a: assert property (ce && trig_wr && !chan_a_tag_release_on && trig_val != GLOBAL_TAG
		|=> !chan_a_tx_release)
		else $error("disabled tag released channel a");
	timer_gate_a: assert property (ce && chan_a_period_timer_start |-> chan_a_tx_release && $past(chan_a_period_timer_on))
		else $error("cycle timer started without enable");
	unused_zero_a: assert property (ce && reg_rd && reg_addr == CHAN_A_TX_TAG_ASSIGN_ADDR |=> reg_rdata[3:1] == 3'h0)
		else $error("unused tag bits read nonzero");
	cover_release_b: cover property (ce && trig_wr && trig_val != GLOBAL_TAG ##1 chan_b_tx_release);
	cover_read_flag: cover property (ce && reg_rd && reg_addr == CHAN_B_REPLY_TIMEOUT_CFG_ADDR && chan_b_late_reply_flag);
endmodule // reply_timeout_tag_release

// ### core/reply_timing_pkg.sv
// Constants and carriers for the reply-timeout monitor and the transmit-tag release
package reply_timing_pkg;
	// Register offsets
	localparam logic [7:0] CHAN_A_REPLY_TIMEOUT_CFG_ADDR = 8'h14;
	localparam logic [7:0] CHAN_B_REPLY_TIMEOUT_CFG_ADDR = 8'h15;
	localparam logic [7:0] CHAN_A_TX_TAG_ASSIGN_ADDR = 8'h16;
	localparam logic [7:0] CHAN_B_TX_TAG_ASSIGN_ADDR = 8'h17;
	// Reset values
	localparam logic [6:0] TIMEOUT_CFG_RESET = 7'h00;
	localparam logic [4:0] TAG_ASSIGN_RESET = 5'h00;
	// Field positions of the reply-timeout register
	localparam int LATE_FLAG_BIT = 7;
	localparam int INTERBYTE_SLACK_HI = 6;
	localparam int INTERBYTE_SLACK_LO = 5;
	localparam int REPLY_SLACK_HI = 4;
	localparam int REPLY_SLACK_LO = 1;
	localparam int MONITOR_ON_BIT = 0;
	// Field positions of the tag register
	localparam int TAG_HI = 7;
	localparam int TAG_LO = 4;
	localparam int TAG_RELEASE_ON_BIT = 0;
	localparam logic [3:0] GLOBAL_TAG = 4'h0;
	// Baseline limits in bit intervals
	localparam logic [4:0] REPLY_BASE_BITS = 5'h0A;
	localparam logic [4:0] INTERBYTE_BASE_BITS = 5'h01;
	// Clock and transfer rates
	localparam int CLK_HZ = 25_000_000;
	localparam int RATE_COM1_BPS = 4_800;
	localparam int RATE_COM2_BPS = 38_400;
	localparam int RATE_COM3_BPS = 230_400;
	localparam int BIT_CYC_COM1 = CLK_HZ / RATE_COM1_BPS;
	localparam int BIT_CYC_COM2 = CLK_HZ / RATE_COM2_BPS;
	localparam int BIT_CYC_COM3 = CLK_HZ / RATE_COM3_BPS;
	localparam logic [1:0] RATE_COM1 = 2'h1;
	localparam logic [1:0] RATE_COM2 = 2'h2;

	// Framer events of one channel, one-cycle pulses
	typedef struct packed {
		logic tx_done;
		logic rx_start;
		logic rx_byte_done;
		logic rx_msg_done;
	} link_evt_s;

	typedef enum logic [1:0] {MON_IDLE, MON_WAIT_REPLY, MON_RECV, MON_GAP} mon_state_e;
endpackage

// ### tb/link_device_model.sv
// Behavioural far side of one link: end of master frame and device reply events
`timescale 1ns/1ps
module link_device_model
	import reply_timing_pkg::*;
(
	// Clock
	input wire logic clk,
	// Framer events toward the monitor
	output link_evt_s evt
);
	initial begin
		evt = '0;
	end
	// Index 3 tx_done, 2 rx_start, 1 rx_byte_done, 0 rx_msg_done
	task automatic pulse(input int which);
		@(posedge clk);
		#1 evt[which] = 1'b1;
		@(posedge clk);
		#1 evt = '0;
	endtask
	// Zero delay keeps the device silent, to provoke a late reply
	task automatic frame(input int dly, input int gap);
		pulse(3);
		if (dly > 0) begin
			repeat (dly) @(posedge clk);
			pulse(2);
			repeat (5) @(posedge clk);
			pulse(1);
			repeat (gap) @(posedge clk);
			pulse(2);
			repeat (5) @(posedge clk);
			pulse(1);
			pulse(0);
		end
	endtask
endmodule // link_device_model

// ### tb/response_timeout_and_tx_trigger_tb.sv
// Self-checking bench for the reply-timeout monitors and the transmit-tag release
`timescale 1ns/1ps
module response_timeout_and_tx_trigger_tb;
	import reply_timing_pkg::*;
	// Short bit so a reply limit of 11 bits is 220 cycles
	localparam int BIT = 20;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic trig_wr = 1'b0;
	logic [3:0] trig_val = 4'h0;
	logic [1:0] tmr_on = 2'b00;
	logic [1:0] rate_a = RATE_COM1;
	logic [1:0] rate_b = RATE_COM1;
	link_evt_s evt_a;
	link_evt_s evt_b;
	wire logic [5:0] ev;
	logic [7:0] cnt [6];
	int n_fail = 0;
	int num_checks = 0;

	always #20 clk = ~clk;

	reply_timeout_tag_release #(.BIT_CYC_SLOW(BIT)) uut (.clk(clk), .srst(srst), .ce(1'b1),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.trig_wr(trig_wr), .trig_val(trig_val), .line_a_evt(evt_a), .line_b_evt(evt_b),
		.line_a_rate(rate_a), .line_b_rate(rate_b),
		.chan_a_period_timer_on(tmr_on[0]), .chan_b_period_timer_on(tmr_on[1]),
		.chan_a_receive_fault_irq(ev[0]), .chan_b_receive_fault_irq(ev[1]),
		.chan_a_tx_release(ev[2]), .chan_b_tx_release(ev[3]),
		.chan_a_period_timer_start(ev[4]), .chan_b_period_timer_start(ev[5]));
	link_device_model ma (.clk(clk), .evt(evt_a));
	link_device_model mb (.clk(clk), .evt(evt_b));

	// Pulse counters: 0/1 irq, 2/3 release, 4/5 timer start
	always @(posedge clk) begin
		for (int i = 0; i < 6; i++) begin
			if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic clr();
		for (int i = 0; i < 6; i++) cnt[i] = 8'h00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check(n, reg_rdata, e);
	endtask
	task automatic trig(input logic [3:0] v);
		clr();
		@(posedge clk);
		#1 {trig_wr, trig_val} = {1'b1, v};
		@(posedge clk);
		#1 trig_wr = 1'b0;
		repeat (3) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////

	task automatic t_regs();
		rdc("cfg_a", 8'h14, 8'h00);
		rdc("cfg_b", 8'h15, 8'h00);
		rdc("tag_a", 8'h16, 8'h00);
		rdc("unmapped", 8'h20, 8'h00);
		wr(8'h14, 8'hFF);
		rdc("cfg_a ro flag", 8'h14, 8'h7F);
		wr(8'h16, 8'hFF);
		rdc("tag_a ro bits", 8'h16, 8'hF1);
	endtask
	// Limit is 11 bit intervals: no irq counted after 11 intervals, exactly one counted 20 cycles later
	task automatic t_late(input int ch, input logic [1:0] r, input int bit_cyc);
		if (ch == 0) rate_a = r;
		else rate_b = r;
		wr(8'h14 + ch[7:0], 8'h03);
		clr();
		if (ch == 0) ma.frame(0, 0);
		else mb.frame(0, 0);
		repeat (11 * bit_cyc) @(posedge clk);
		check("irq early", cnt[ch], 8'h00);
		repeat (20) @(posedge clk);
		check("irq", cnt[ch], 8'h01);
		check("other irq", cnt[1 - ch], 8'h00);
		rdc("flag set", 8'h14 + ch[7:0], 8'h83);
		rdc("flag cleared", 8'h14 + ch[7:0], 8'h03);
		rate_a = RATE_COM1;
		rate_b = RATE_COM1;
	endtask
	task automatic t_reply(input logic [7:0] cfg, input int dly, input int gap, input logic [7:0] n);
		wr(8'h14, cfg);
		clr();
		ma.frame(dly, gap);
		repeat (260) @(posedge clk);
		check("irq count", cnt[0], n);
		rdc("cfg read", 8'h14, cfg | {n[0], 7'h00});
	endtask
	task automatic t_trig();
		tmr_on = 2'b01;
		wr(8'h16, 8'h51);
		trig(4'h5);
		check("rel a", cnt[2], 8'h01);
		check("rel b", cnt[3], 8'h00);
		check("tstart a", cnt[4], 8'h01);
		trig(4'h3);
		check("rel a miss", cnt[2], 8'h00);
		trig(4'h0);
		check("global a", cnt[2], 8'h01);
		check("global b", cnt[3], 8'h01);
		check("tstart b", cnt[5], 8'h00);
		wr(8'h16, 8'h50);
		trig(4'h5);
		check("disabled", cnt[2], 8'h00);
		wr(8'h17, 8'h91);
		rdc("tag_b", 8'h17, 8'h91);
		trig(4'h9);
		check("rel b own", cnt[3], 8'h01);
		check("rel a other", cnt[2], 8'h00);
		check("tstart b off", cnt[5], 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		clr();
		repeat (8) @(posedge clk);
		#1 srst = 1'b0;
		t_regs();
		t_late(0, RATE_COM1, BIT);
		t_late(0, RATE_COM2, BIT_CYC_COM2);
		t_late(1, 2'h3, BIT_CYC_COM3);
		t_reply(8'h03, 200, 5, 8'h00);
		t_reply(8'h63, 50, 60, 8'h00);
		t_reply(8'h03, 50, 60, 8'h01);
		t_reply(8'h02, 0, 0, 8'h00);
		t_trig();
		conclude();
	end
	// About 10500 cycles expected, mostly the COM2-rate timeout; generous margin
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		conclude();
	end
endmodule // response_timeout_and_tx_trigger_tb
